//--- include/mdi_pkg.sv
// Constants and types shared by the motor driver register slave and its bus master
// Contract
// [RULE_01] Pointer load: write address, then pointer byte
// [RULE_02] Pointer is kept between transactions
// [RULE_03] Read: acknowledge, then data on next cycle
// [RULE_04] Master ends read with NACK then STOP
// [RULE_05] Read ACK advances pointer, sends next register
// [RULE_06] Other register read: pointer, repeated START, read
// [RULE_07] No repeated START: later bytes are writes
// [RULE_08] Every write starts with pointer byte
// [RULE_09] Device acknowledges each written data byte
// [RULE_10] Master ends write with STOP
// [RULE_11] Multi-byte write advances pointer per byte
// [RULE_12] Answer only bus address 0x06
// [RULE_13] Registers at 0x20, 0x21, 0x22 with defaults
// [RULE_14] drive_control bit 7 is drive on
// [RULE_15] drive_control bit 6 allows overdrive
// [RULE_16] drive_control bit 5 selects overdrive side
// [RULE_17] level_control bits 7:5 select input resistance
// [RULE_18] level_control bits 4:2 select regulator level
// [RULE_19] Status bit 3 shows supply valid
// [RULE_20] Status bit 2 shows regulator valid
// [RULE_21] Status bit 1 shows thermal ok
// [RULE_22] Unused status bits read zero
// [RULE_23] Status and reserved writes acked, ignored; a drive_control write clears its reserved bits to zero
package mdi_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h06;
  localparam logic [7:0] REG_DRIVE = 8'h20;
  localparam logic [7:0] REG_LEVEL = 8'h21;
  localparam logic [7:0] REG_STATUS = 8'h22;
  localparam logic [7:0] DRIVE_RESET = 8'h90;
  localparam logic [7:0] LEVEL_RESET = 8'h2c;
  localparam logic [7:0] STATUS_RESET = 8'h0e;
  localparam logic [7:0] PTR_RESET = 8'h20;
  localparam logic [7:0] DRIVE_WMASK = 8'he0;
  localparam logic [7:0] LEVEL_WMASK = 8'hfc;
  localparam int DRIVE_ON_BIT = 7;
  localparam int OVERDRIVE_BIT = 6;
  localparam int SIDE_BIT = 5;
  localparam int RES_MSB = 7;
  localparam int RES_LSB = 5;
  localparam int REG_MSB = 4;
  localparam int REG_LSB = 2;
  localparam int SUPPLY_BIT = 3;
  localparam int REGOK_BIT = 2;
  localparam int THERM_BIT = 1;
  // Link clock divider: 125 MHz / (4 * 79) is just under 400 kHz
  localparam int SYS_HZ = 125000000;
  localparam int SCL_HZ = 400000;
  localparam int HALF_CYC = (SYS_HZ + 2 * SCL_HZ - 1) / (2 * SCL_HZ);
  typedef enum logic [2:0] {
    MDI_IDLE = 3'b000,
    MDI_ADDR = 3'b001,
    MDI_AACK = 3'b011,
    MDI_RXB = 3'b010,
    MDI_RACK = 3'b110,
    MDI_TXB = 3'b111,
    MDI_TACK = 3'b101
  } mdi_state_e;
endpackage

//--- include/mdi_if.sv
// Two-wire link joining the register slave and its bus master
`timescale 1ns/1ps
interface mdi_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain wired-and with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe,
                output sda_m_o, output sda_m_oe);
endinterface

//--- logic/mdi_sync.sv
// Two flip-flop synchroniser with edge flags for the link pins
`timescale 1ns/1ps
module mdi_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } mdi_sync_s;
  mdi_sync_s st_ff;
  mdi_sync_s nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Only s2 and s3 are looked at; s1 feeds s2 alone
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= 3'b111;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.s2;
  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;
endmodule

//--- logic/mdi_dev.sv
// Register slave end: address match, pointer, three registers, pin outputs
`timescale 1ns/1ps
module mdi_dev (
  input wire logic clk_sys,
  input wire logic sys_rst,
  mdi_if.dev bus,
  input wire logic supply_ok,
  input wire logic regulator_ok,
  input wire logic thermal_ok,
  output logic drive_on,
  output logic overdrive_allow,
  output logic overdrive_side_select,
  output logic [2:0] input_res_select,
  output logic [2:0] regulator_level_select
);
  // All slave state except the two pin synchronisers in one record; nxt_st is its next value
  typedef struct packed {
    mdi_pkg::mdi_state_e state;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic first;
    logic rd;
    logic ack_go;
    logic sda_low;
    logic [7:0] ptr;
    logic [7:0] drive;
    logic [7:0] level;
    logic [2:0] st_meta;
    logic [7:0] status;
    logic [2:0] flags;
  } mdi_dev_s;
  mdi_dev_s st_ff;
  mdi_dev_s nxt_st;
  // Synchronised pin levels and edges
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;
  logic [7:0] rd_byte;

  // SCL and SDA come from pins, so both pass the two-stage synchroniser
  mdi_sync u_scl (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin_in(bus.scl),
    .level(scl_lvl), .rise(scl_rise), .fall(scl_fall));
  mdi_sync u_sda (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin_in(bus.sda),
    .level(sda_lvl), .rise(sda_rise), .fall(sda_fall));

  // Register read mux; unmapped pointers read zero
  function automatic logic [7:0] reg_read(input mdi_dev_s s);
    logic [7:0] v;
    v = 8'h00;
    if (s.ptr == mdi_pkg::REG_DRIVE) v = s.drive;
    else if (s.ptr == mdi_pkg::REG_LEVEL) v = s.level;
    else if (s.ptr == mdi_pkg::REG_STATUS) v = s.status;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Byte engine: samples on SCL rise, changes SDA on SCL fall
  always_comb begin
    nxt_st = st_ff;
    rd_byte = 8'h00;
    // Status inputs come from other domains, so synchronise them first
    nxt_st.st_meta = {supply_ok, regulator_ok, thermal_ok};
    nxt_st.flags = st_ff.st_meta;
    // Status is rebuilt every cycle, so it never holds a stale value
    nxt_st.status = 8'h00; // see [RULE_22]
    nxt_st.status[mdi_pkg::SUPPLY_BIT] = st_ff.flags[2]; // see [RULE_19]
    nxt_st.status[mdi_pkg::REGOK_BIT] = st_ff.flags[1]; // see [RULE_20]
    nxt_st.status[mdi_pkg::THERM_BIT] = st_ff.flags[0]; // see [RULE_21]
    if (scl_lvl && sda_fall) begin
      // START or repeated START; pointer is not touched
      nxt_st.state = mdi_pkg::MDI_ADDR; // see [RULE_02]
      nxt_st.bitcnt = 4'h0;
      nxt_st.sda_low = 1'b0;
    end else if (scl_lvl && sda_rise) begin
      // STOP: let go of SDA and wait for the next START
      nxt_st.state = mdi_pkg::MDI_IDLE;
      nxt_st.sda_low = 1'b0;
    end else if (scl_rise) begin
      // Rising SCL: take in received bits, count sent ones
      unique case (st_ff.state)
        mdi_pkg::MDI_ADDR, mdi_pkg::MDI_RXB: begin
          nxt_st.shift = {st_ff.shift[6:0], sda_lvl};
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
        end
        mdi_pkg::MDI_TXB: begin
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
        end
        mdi_pkg::MDI_TACK: begin
          // Master ACK keeps the read going, NACK ends it
          nxt_st.ack_go = ~sda_lvl; // see [RULE_05]
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      // Falling SCL: SDA may only change now; apart from the release at START or STOP, drive updates are here
      unique case (st_ff.state)
        mdi_pkg::MDI_ADDR: begin
          if (st_ff.bitcnt == 4'h8) begin
            if (st_ff.shift[7:1] == mdi_pkg::DEV_ADDR) begin // see [RULE_12]
              nxt_st.state = mdi_pkg::MDI_AACK;
              nxt_st.sda_low = 1'b1;
              nxt_st.rd = st_ff.shift[0];
            end else begin
              // Foreign address: no ACK, keep off the bus until a START
              nxt_st.state = mdi_pkg::MDI_IDLE;
            end
          end
        end
        mdi_pkg::MDI_AACK, mdi_pkg::MDI_RACK: begin
          nxt_st.bitcnt = 4'h0;
          if (st_ff.state == mdi_pkg::MDI_AACK) begin
            nxt_st.first = 1'b1;
          end
          if (st_ff.rd && st_ff.state == mdi_pkg::MDI_AACK) begin
            // First data bit goes out right after the address ACK
            nxt_st.state = mdi_pkg::MDI_TXB; // see [RULE_03]
            rd_byte = reg_read(st_ff);
            nxt_st.shift = rd_byte;
            nxt_st.sda_low = ~rd_byte[7];
          end else begin
            // Write address or any data ACK: receive the next byte
            nxt_st.state = mdi_pkg::MDI_RXB;
            nxt_st.sda_low = 1'b0;
          end
        end
        mdi_pkg::MDI_RXB: begin
          if (st_ff.bitcnt == 4'h8) begin
            nxt_st.state = mdi_pkg::MDI_RACK;
            nxt_st.sda_low = 1'b1; // see [RULE_09]
            nxt_st.first = 1'b0;
            if (st_ff.first) begin
              nxt_st.ptr = st_ff.shift; // see [RULE_01]
            end else begin
              // Data without repeated START overwrites the register
              // Status writes are acked but dropped; reserved bits are acked but written as zero
              if (st_ff.ptr == mdi_pkg::REG_DRIVE) begin // see [RULE_07]
                nxt_st.drive = st_ff.shift & mdi_pkg::DRIVE_WMASK; // see [RULE_23]
              end else if (st_ff.ptr == mdi_pkg::REG_LEVEL) begin
                nxt_st.level = st_ff.shift & mdi_pkg::LEVEL_WMASK; // see [RULE_23]
              end
              // The pointer wraps past 0xff; unmapped addresses read zero
              nxt_st.ptr = st_ff.ptr + 8'h01; // see [RULE_11]
            end
          end
        end
        mdi_pkg::MDI_TXB: begin
          if (st_ff.bitcnt == 4'h8) begin
            // Last bit sent: let go of SDA so the master can ACK or NACK
            nxt_st.state = mdi_pkg::MDI_TACK;
            nxt_st.sda_low = 1'b0;
          end else begin
            nxt_st.shift = {st_ff.shift[6:0], 1'b0};
            nxt_st.sda_low = ~st_ff.shift[6];
          end
        end
        mdi_pkg::MDI_TACK: begin
          nxt_st.bitcnt = 4'h0;
          if (st_ff.ack_go) begin
            nxt_st.ptr = st_ff.ptr + 8'h01; // see [RULE_05]
            nxt_st.rd = 1'b1;
            // Master ACK: send the next register at once, from the new pointer
            nxt_st.state = mdi_pkg::MDI_TXB;
            rd_byte = reg_read(nxt_st);
            nxt_st.shift = rd_byte;
            nxt_st.sda_low = ~rd_byte[7];
          end else begin
            // NACK: a STOP follows; the pointer stays on the byte just sent
            nxt_st.state = mdi_pkg::MDI_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset loads register defaults; pointer starts at the first control register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.state <= mdi_pkg::MDI_IDLE;
      st_ff.ptr <= mdi_pkg::PTR_RESET;
      st_ff.drive <= mdi_pkg::DRIVE_RESET; // see [RULE_13]
      st_ff.level <= mdi_pkg::LEVEL_RESET;
      st_ff.status <= mdi_pkg::STATUS_RESET;
      st_ff.st_meta <= 3'b111;
      st_ff.flags <= 3'b111;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain: enable only while pulling low
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = st_ff.sda_low;
  // Field outputs are plain register bits, so they come straight from flops
  assign drive_on = st_ff.drive[mdi_pkg::DRIVE_ON_BIT]; // see [RULE_14]
  assign overdrive_allow = st_ff.drive[mdi_pkg::OVERDRIVE_BIT]; // see [RULE_15]
  assign overdrive_side_select = st_ff.drive[mdi_pkg::SIDE_BIT]; // see [RULE_16]
  assign input_res_select = st_ff.level[mdi_pkg::RES_MSB:mdi_pkg::RES_LSB]; // see [RULE_17]
  assign regulator_level_select = st_ff.level[mdi_pkg::REG_MSB:mdi_pkg::REG_LSB]; // see [RULE_18]
endmodule

//--- logic/mdi_host.sv
// Bus master end: one command runs pointer load plus write or read
`timescale 1ns/1ps
module mdi_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  mdi_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_busy,
  output logic done,
  output logic nack_err,
  output logic [7:0] rdata
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BYTE = 3'b011,
    H_ACK = 3'b010, H_STOP = 3'b110, H_RSTART = 3'b111
  } mdi_hst_e;
  typedef struct packed {
    mdi_hst_e state;
    logic [8:0] div;
    logic [1:0] ph;
    logic [3:0] step;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic [7:0] ptr;
    logic [7:0] wd;
    logic scl;
    logic sda;
    logic busy;
    logic done;
    logic nack;
    logic [7:0] rdata;
  } mdi_hst_s;
  mdi_hst_s st_ff;
  mdi_hst_s nxt_st;
  logic sda_lvl;

  mdi_sync u_sda (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin_in(bus.sda),
    .level(sda_lvl), .rise(), .fall());

  ////////////////////////////////////////////////////////////////////////
  // Quarter-period tick drives each phase; step walks the byte list
  // Steps: 0 addr-w, 1 pointer, 2 data or readdr, 3 read byte
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.div = st_ff.div + 9'h001;
    if (st_ff.state == H_IDLE) begin
      nxt_st.div = 9'h000;
      if (cmd_valid) begin
        nxt_st.state = H_START;
        nxt_st.busy = 1'b1;
        nxt_st.nack = 1'b0;
        nxt_st.rd = cmd_read;
        nxt_st.ptr = cmd_ptr;
        nxt_st.wd = cmd_wdata;
        nxt_st.ph = 2'd0;
        nxt_st.step = 4'h0;
      end
    end else if (st_ff.div == 9'(mdi_pkg::HALF_CYC / 2)) begin
      nxt_st.div = 9'h000;
      nxt_st.ph = st_ff.ph + 2'd1;
      unique case (st_ff.state)
        H_START, H_RSTART: begin
          // SDA falls while SCL high, then SCL low
          if (st_ff.ph == 2'd0) begin
            nxt_st.sda = 1'b1;
            nxt_st.scl = 1'b1;
          end
          if (st_ff.ph == 2'd1) nxt_st.sda = 1'b0;
          if (st_ff.ph == 2'd2) nxt_st.scl = 1'b0;
          if (st_ff.ph == 2'd3) begin
            nxt_st.state = H_BYTE;
            nxt_st.bitn = 4'h0;
            // Write address for pointer load, read address after repeat
            nxt_st.sh = (st_ff.state == H_RSTART) ?
              {mdi_pkg::DEV_ADDR, 1'b1} : {mdi_pkg::DEV_ADDR, 1'b0}; // see [RULE_01]
          end
        end
        H_BYTE, H_ACK: begin
          if (st_ff.ph == 2'd0) begin
            // Release SDA for slave bits, its ACK and the closing NACK of a read
            if (st_ff.state == H_ACK)
              nxt_st.sda = 1'b1; // see [RULE_04]
            else
              nxt_st.sda = (st_ff.step == 4'h3) ? 1'b1 : st_ff.sh[7]; // see [RULE_09]
          end
          if (st_ff.ph == 2'd1) nxt_st.scl = 1'b1;
          if (st_ff.ph == 2'd2 && st_ff.state == H_BYTE) begin
            nxt_st.sh = {st_ff.sh[6:0], sda_lvl};
            nxt_st.bitn = st_ff.bitn + 4'h1;
          end
          if (st_ff.ph == 2'd2 && st_ff.state == H_ACK && st_ff.step != 4'h3)
            nxt_st.nack = sda_lvl;
          if (st_ff.ph == 2'd3) begin
            nxt_st.scl = 1'b0;
            if (st_ff.state == H_BYTE && st_ff.bitn == 4'h8) begin
              nxt_st.state = H_ACK;
              if (st_ff.step == 4'h3) nxt_st.rdata = st_ff.sh;
            end else if (st_ff.state == H_ACK) begin
              nxt_st.bitn = 4'h0;
              nxt_st.step = st_ff.step + 4'h1;
              if (st_ff.nack || st_ff.step == 4'h3 || (st_ff.step == 4'h2 && !st_ff.rd)) begin
                nxt_st.state = H_STOP; // see [RULE_10]
              end else if (st_ff.step == 4'h1 && st_ff.rd) begin
                nxt_st.state = H_RSTART; // see [RULE_06]
                nxt_st.step = 4'h2; // Read address is step 2, its data step 3
              end else begin
                // Next byte follows at once: pointer after address, data after pointer, read byte after read address
                nxt_st.state = H_BYTE; // see [RULE_08]
                nxt_st.sh = (st_ff.step == 4'h0) ? st_ff.ptr : st_ff.wd;
              end
            end
          end
        end
        H_STOP: begin
          if (st_ff.ph == 2'd0) nxt_st.sda = 1'b0;
          if (st_ff.ph == 2'd1) nxt_st.scl = 1'b1;
          if (st_ff.ph == 2'd2) nxt_st.sda = 1'b1;
          if (st_ff.ph == 2'd3) begin
            nxt_st.state = H_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
          end
        end
        default: nxt_st.state = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.state <= H_IDLE;
      st_ff.scl <= 1'b1;
      st_ff.sda <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = ~st_ff.scl;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = ~st_ff.sda;
  assign cmd_busy = st_ff.busy;
  assign done = st_ff.done;
  assign nack_err = st_ff.nack;
  assign rdata = st_ff.rdata;
endmodule

//--- verification/mdi_properties.sv
// Concurrent checks on the two-wire link between the master end and the register slave
`timescale 1ns/1ps
module mdi_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] hold_cnt_ff;
  logic [3:0] nxt_hold_cnt;
  logic scl_d_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Count link clock pulses while the slave holds data low; saturates so it never wraps
  always_comb begin
    nxt_hold_cnt = hold_cnt_ff;
    if (!sda_s_oe) begin
      nxt_hold_cnt = 4'h0;
    end else if (scl && !scl_d_ff && hold_cnt_ff != 4'hf) begin
      nxt_hold_cnt = hold_cnt_ff + 4'h1;
    end
  end

  // Helper registers, idle values in reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hold_cnt_ff <= 4'h0;
      scl_d_ff <= 1'b1;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
      scl_d_ff <= scl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_dev_edge_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave changed data while clock high");
  a_reset_idle: assert property ($fell(sys_rst) |-> !sda_s_oe && !sda_m_oe && !scl_oe)
    else $error("link not released after reset");
  a_start_clear: assert property (scl && $rose(sda_m_oe) |-> !sda_s_oe)
    else $error("slave holds data at start");
  a_stop_clear: assert property (scl && $fell(sda_m_oe) |-> !sda_s_oe)
    else $error("slave holds data at stop");
  a_drive_low_only: assert property ((scl_oe -> !scl_o) && (sda_m_oe -> !sda_m_o)
    && (sda_s_oe -> !sda_s_o))
    else $error("pin driven high");
  a_hold_span: assert property (hold_cnt_ff <= 4'h9)
    else $error("slave held data low past one byte and acknowledge");
  a_ack_clocked: assert property ($rose(sda_s_oe) |-> ##[1:400] $rose(scl))
    else $error("no clock pulse after slave pulled data low");
  a_scl_high_span: assert property ($rose(scl) |-> scl[*8])
    else $error("link clock high phase too short");
endmodule

//--- verification/motor_driver_i2c_register_slave_bench.sv
// Self-checking bench: master end and register slave end joined over the link
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end
module motor_driver_i2c_register_slave_bench;
  logic clk_sys;
  logic sys_rst;
  logic supply_ok;
  logic regulator_ok;
  logic thermal_ok;
  logic cmd_valid;
  logic cmd_read;
  logic [7:0] cmd_ptr;
  logic [7:0] cmd_wdata;
  logic cmd_busy;
  logic done;
  logic nack_err;
  logic [7:0] rdata;
  logic drive_on;
  logic overdrive_allow;
  logic overdrive_side_select;
  logic [2:0] input_res_select;
  logic [2:0] regulator_level_select;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 7501;
  logic [8:0] notes[$];
  logic [8:0] note;
  logic [7:0] wd;
  logic [7:0] drv;
  logic [2:0] st;

  ////////////////////////////////////////////////////////////////////////////////
  // Both ends face each other across one link; checker watches its wires
  mdi_if mdi_if_i();
  mdi_dev mdi_dev_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(mdi_if_i.dev),
    .supply_ok(supply_ok), .regulator_ok(regulator_ok), .thermal_ok(thermal_ok),
    .drive_on(drive_on), .overdrive_allow(overdrive_allow),
    .overdrive_side_select(overdrive_side_select), .input_res_select(input_res_select),
    .regulator_level_select(regulator_level_select));
  mdi_host mdi_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(mdi_if_i.host),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata),
    .cmd_busy(cmd_busy), .done(done), .nack_err(nack_err), .rdata(rdata));
  mdi_properties mdi_properties_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .scl_o(mdi_if_i.scl_o), .scl_oe(mdi_if_i.scl_oe), .sda_m_o(mdi_if_i.sda_m_o),
    .sda_m_oe(mdi_if_i.sda_m_oe), .sda_s_o(mdi_if_i.sda_s_o), .sda_s_oe(mdi_if_i.sda_s_oe),
    .scl(mdi_if_i.scl), .sda(mdi_if_i.sda));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Register fields show up directly on the slave's level outputs
  task automatic check_outs(input logic [7:0] dv, input logic [7:0] lv);
    @(negedge clk_sys);
    `CHK(drive_on, dv[7])
    `CHK(overdrive_allow, dv[6])
    `CHK(overdrive_side_select, dv[5])
    `CHK(input_res_select, lv[7:5])
    `CHK(regulator_level_select, lv[4:2])
  endtask

  // One command; valid is held until the master reports busy, so it is never missed
  task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] wdat,
                      input logic [7:0] exp);
    int n;
    notes.push_back({rd, exp});
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_ptr <= ptr;
    cmd_wdata <= wdat;
    n = 0;
    do @(negedge clk_sys); while (cmd_busy !== 1'b1 && ++n < 100);
    if (n >= 100) miscompares++;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do @(negedge clk_sys); while (cmd_busy !== 1'b0 && ++n < 20000);
    if (n >= 20000) miscompares++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Result monitor: each done pulse retires the oldest note
  always @(negedge clk_sys) begin
    if (done === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      `CHK(nack_err, 1'b0)
      if (note[8]) `CHK(rdata, note[7:0])
    end
  end

  // Whole run is about 80k cycles of link traffic
  initial begin
    repeat (95000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_ptr = 8'h00;
    cmd_wdata = 8'h00;
    supply_ok = 1'b1;
    regulator_ok = 1'b1;
    thermal_ok = 1'b1;
    do_reset();
    check_outs(mdi_pkg::DRIVE_RESET, mdi_pkg::LEVEL_RESET);
    xfer(1'b1, mdi_pkg::REG_LEVEL, 8'h00, 8'h2c);
    wd = 8'($random(seed));
    drv = wd & 8'he0;
    xfer(1'b0, mdi_pkg::REG_DRIVE, wd, 8'h00);
    check_outs(drv, 8'h2c);
    // Status write must be swallowed; the read below shows only live inputs
    xfer(1'b0, mdi_pkg::REG_STATUS, ~wd, 8'h00);
    st = 3'($random(seed));
    // Status inputs change on a rising edge like all other stimulus
    @(posedge clk_sys);
    supply_ok <= st[2];
    regulator_ok <= st[1];
    thermal_ok <= st[0];
    xfer(1'b1, mdi_pkg::REG_STATUS, 8'h00, {4'h0, st, 1'b0});
    wd = 8'($random(seed));
    xfer(1'b0, mdi_pkg::REG_LEVEL, wd, 8'h00);
    check_outs(drv, wd & 8'hfc);
    xfer(1'b1, mdi_pkg::REG_DRIVE, 8'h00, drv);
    xfer(1'b1, 8'hff, 8'h00, 8'h00);
    // Second reset in mid-run restores defaults
    do_reset();
    check_outs(8'h90, 8'h2c);
    `CHK(notes.size(), 0)
    conclude();
  end
endmodule
